// *** sats_pkg.sv ***
// constants of the alert and limit-check block
//
// Operation
// - With latching off, the alert pin is active only while an enabled source is present.
// - With latching on, an alert is caught when its source asserts and held until the matching status or result read.
// - Pin function 0 is interrupt mode; 1 is switch mode, overriding interrupts, blocking pin triggers, following the axis enables.
// - The status-flag enable lets any front-end or system status flag drive the pin, and blocks them when clear.
// - The conversion-done enable lets completion of the configured conversion set drive the pin, and blocks it when clear.
// - A threshold alert needs 1 to 4 consecutive out-of-limit results, chosen by field codes 0 to 3.
// - The temperature enable lets temperature limit crossings drive the pin, and blocks them when clear.
// - The Z, Y and X enables each let that axis limit crossings drive the pin, and block them when clear.
// - Each axis limit register holds the signed upper limit in its high byte and the signed lower limit in its low byte.
// - A limit stands for full scale divided by 128 times the signed code, so comparison scales with the range.
// - After reset the magnetic limits stand at plus and minus 98 percent of full scale.
// - An axis is limit-checked only while its limit-check enable bit is set.
// - The range field selects the full scale for scaling, and its unused code 3 acts as code 0.
package sats_pkg;

	// register offsets
	localparam logic [3:0] SATS_OFS_ALERT_CFG = 4'h3;
	localparam logic [3:0] SATS_OFS_X_LIMITS  = 4'h4;
	localparam logic [3:0] SATS_OFS_Y_LIMITS  = 4'h5;

	// reset values
	localparam logic [15:0] SATS_RST_ALERT_CFG = 16'h0000;
	localparam logic [15:0] SATS_RST_LIMITS    = 16'h7D83;

	// writable bits of the alert configuration
	localparam logic [15:0] SATS_CFG_WMASK = 16'h393F;

	// alert configuration field positions
	localparam int SATS_BIT_LATCH   = 13;
	localparam int SATS_BIT_SWITCH  = 12;
	localparam int SATS_BIT_STATUS  = 11;
	localparam int SATS_BIT_DONE    = 8;
	localparam int SATS_POS_COUNT   = 4;
	localparam int SATS_BIT_TEMP    = 3;
	localparam int SATS_BIT_Z       = 2;
	localparam int SATS_BIT_Y       = 1;
	localparam int SATS_BIT_X       = 0;

	// limit register layout
	localparam int SATS_POS_UPPER = 8;
	localparam int SATS_POS_LOWER = 0;

	// one limit code step is 1/128 of full scale; full scale of the base range is 2^15
	localparam int SATS_LIMIT_SHIFT = 8;

	// saturation point of the consecutive crossing counter
	localparam logic [2:0] SATS_RUN_MAX = 3'h4;

endpackage

// *** sats_limit_chan.sv ***
// one channel limit comparator with consecutive crossing counter
module sats_limit_chan
	import sats_pkg::*;
(
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               rst_b,
	// result stream
	input  wire logic               resultValid,
	input  wire logic signed [17:0] resultValue,
	// configuration
	input  wire logic               checkEnable,
	input  wire logic signed [7:0]  upperCode,
	input  wire logic signed [7:0]  lowerCode,
	input  wire logic [1:0]         scaleShift,
	input  wire logic [1:0]         countSelect,
	// state
	output logic                    limitHit
);

	logic signed [17:0] upperLevel;
	logic signed [17:0] lowerLevel;
	logic               crossed;
	logic [2:0]         run_q;
	logic [2:0]         run_d;

	// code times full scale over 128, widened to the selected range
	assign upperLevel = 18'(upperCode) <<< (SATS_LIMIT_SHIFT + int'(scaleShift));
	assign lowerLevel = 18'(lowerCode) <<< (SATS_LIMIT_SHIFT + int'(scaleShift));
	assign crossed    = (resultValue > upperLevel) || (resultValue < lowerLevel);

	always_comb begin
		if (!crossed) begin
			run_d = 3'h0;
		end else if (run_q == SATS_RUN_MAX) begin
			run_d = run_q;
		end else begin
			run_d = run_q + 3'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			run_q    <= 3'h0;
			limitHit <= 1'b0;
		end else if (!checkEnable) begin
			run_q    <= 3'h0;
			limitHit <= 1'b0;
		end else if (resultValid) begin
			run_q    <= run_d;
			limitHit <= run_d > {1'b0, countSelect};
		end
	end

	AST_RUN_RESTART: assert property (@(posedge mclk) disable iff (!rst_b)
		(checkEnable && resultValid && !crossed) |=> (run_q == 3'h0) && !limitHit)
		else $error("counter did not restart on in-limit result");

	AST_HIT_AT_COUNT: assert property (@(posedge mclk) disable iff (!rst_b)
		(checkEnable && resultValid && crossed && (run_q == {1'b0, countSelect}))
		|=> limitHit)
		else $error("limit hit missing after selected crossing count");

	AST_NO_EARLY_HIT: assert property (@(posedge mclk) disable iff (!rst_b)
		(checkEnable && resultValid && (run_d <= {1'b0, countSelect})) |=> !limitHit)
		else $error("limit hit before selected crossing count");

endmodule

// *** sats_alert.sv ***
// alert pin logic: configuration registers, limit checks and pin drive
module sats_alert
	import sats_pkg::*;
(
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               rst_b,
	// register access from the serial front end
	input  wire logic               regWrite,
	input  wire logic               regRead,
	input  wire logic [3:0]         regAddr,
	input  wire logic [15:0]        regWriteData,
	output logic [15:0]             regReadData,
	// register reads seen elsewhere that clear latched alerts
	input  wire logic               statusRead,
	input  wire logic               resultRead,
	// conversion results, one pulse per new value
	input  wire logic               xValid,
	input  wire logic signed [17:0] xValue,
	input  wire logic               yValid,
	input  wire logic signed [17:0] yValue,
	input  wire logic               zValid,
	input  wire logic signed [17:0] zValue,
	input  wire logic               tempValid,
	input  wire logic signed [17:0] tempValue,
	// configuration held outside this block
	input  wire logic [1:0]         xRange,
	input  wire logic [1:0]         yRange,
	input  wire logic [1:0]         zRange,
	input  wire logic [2:0]         limitCheckEnable,
	input  wire logic [15:0]        zLimits,
	input  wire logic [15:0]        tempLimits,
	// status sources
	input  wire logic               frontEndStatusAny,
	input  wire logic               systemStatusAny,
	input  wire logic               conversionSetDone,
	// pin side
	output logic                    alertPin_b,
	output logic                    alertTriggerEnable
);

	logic [15:0] alertCfg_q;
	logic [15:0] xLimits_q;
	logic [15:0] yLimits_q;
	logic        latchSel;
	logic        switchSel;
	logic [3:0]  limitHit;
	logic [3:0]  pinEnable;
	logic        srcLimit;
	logic        srcStatus;
	logic        srcDone;
	logic        srcSwitch;
	logic        anySrc;
	logic        limitPrev_q;
	logic        statusPrev_q;
	logic        donePrev_q;
	logic        limitLatch_q;
	logic        statusLatch_q;
	logic        doneLatch_q;
	logic        anyLatched;
	logic        alertActive;

	// code 3 is unused and scales like code 0
	function automatic logic [1:0] rangeShift(input logic [1:0] code);
		unique case (code)
			2'h1:    rangeShift = 2'h0;
			2'h2:    rangeShift = 2'h2;
			default: rangeShift = 2'h1;
		endcase
	endfunction

	assign latchSel  = alertCfg_q[SATS_BIT_LATCH];
	assign switchSel = alertCfg_q[SATS_BIT_SWITCH];
	assign pinEnable = {alertCfg_q[SATS_BIT_TEMP], alertCfg_q[SATS_BIT_Z],
		alertCfg_q[SATS_BIT_Y], alertCfg_q[SATS_BIT_X]};

	// register file
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			alertCfg_q <= SATS_RST_ALERT_CFG;
			xLimits_q  <= SATS_RST_LIMITS;
			yLimits_q  <= SATS_RST_LIMITS;
		end else if (regWrite) begin
			if (regAddr == SATS_OFS_ALERT_CFG) begin
				alertCfg_q <= regWriteData & SATS_CFG_WMASK;
			end
			if (regAddr == SATS_OFS_X_LIMITS) begin
				xLimits_q <= regWriteData;
			end
			if (regAddr == SATS_OFS_Y_LIMITS) begin
				yLimits_q <= regWriteData;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			regReadData <= 16'h0000;
		end else if (regRead) begin
			unique case (regAddr)
				SATS_OFS_ALERT_CFG: regReadData <= alertCfg_q;
				SATS_OFS_X_LIMITS:  regReadData <= xLimits_q;
				SATS_OFS_Y_LIMITS:  regReadData <= yLimits_q;
				default:            regReadData <= 16'h0000;
			endcase
		end
	end

	// limit checks: x, y, z and temperature
	sats_limit_chan xChan (
		.mclk        (mclk),
		.rst_b       (rst_b),
		.resultValid (xValid),
		.resultValue (xValue),
		.checkEnable (limitCheckEnable[0]),
		.upperCode   (xLimits_q[SATS_POS_UPPER +: 8]),
		.lowerCode   (xLimits_q[SATS_POS_LOWER +: 8]),
		.scaleShift  (rangeShift(xRange)),
		.countSelect (alertCfg_q[SATS_POS_COUNT +: 2]),
		.limitHit    (limitHit[0])
	);

	sats_limit_chan yChan (
		.mclk        (mclk),
		.rst_b       (rst_b),
		.resultValid (yValid),
		.resultValue (yValue),
		.checkEnable (limitCheckEnable[1]),
		.upperCode   (yLimits_q[SATS_POS_UPPER +: 8]),
		.lowerCode   (yLimits_q[SATS_POS_LOWER +: 8]),
		.scaleShift  (rangeShift(yRange)),
		.countSelect (alertCfg_q[SATS_POS_COUNT +: 2]),
		.limitHit    (limitHit[1])
	);

	sats_limit_chan zChan (
		.mclk        (mclk),
		.rst_b       (rst_b),
		.resultValid (zValid),
		.resultValue (zValue),
		.checkEnable (limitCheckEnable[2]),
		.upperCode   (zLimits[SATS_POS_UPPER +: 8]),
		.lowerCode   (zLimits[SATS_POS_LOWER +: 8]),
		.scaleShift  (rangeShift(zRange)),
		.countSelect (alertCfg_q[SATS_POS_COUNT +: 2]),
		.limitHit    (limitHit[2])
	);

	// temperature has no range; its code step is fixed at the base scale
	sats_limit_chan tempChan (
		.mclk        (mclk),
		.rst_b       (rst_b),
		.resultValid (tempValid),
		.resultValue (tempValue),
		.checkEnable (1'b1),
		.upperCode   (tempLimits[SATS_POS_UPPER +: 8]),
		.lowerCode   (tempLimits[SATS_POS_LOWER +: 8]),
		.scaleShift  (2'h0),
		.countSelect (alertCfg_q[SATS_POS_COUNT +: 2]),
		.limitHit    (limitHit[3])
	);

	// alert sources
	assign srcLimit  = |(limitHit & pinEnable);
	assign srcStatus = alertCfg_q[SATS_BIT_STATUS]
		&& (frontEndStatusAny || systemStatusAny);
	assign srcDone   = alertCfg_q[SATS_BIT_DONE] && conversionSetDone;
	assign anySrc    = srcLimit || srcStatus || srcDone;
	// the switch relies on the host having set the axis limit-check enables
	assign srcSwitch = |(limitHit[2:0] & pinEnable[2:0]);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			limitPrev_q  <= 1'b0;
			statusPrev_q <= 1'b0;
			donePrev_q   <= 1'b0;
		end else begin
			limitPrev_q  <= srcLimit;
			statusPrev_q <= srcStatus;
			donePrev_q   <= srcDone;
		end
	end

	// latched sources: a new edge wins over a clearing read in the same cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			limitLatch_q  <= 1'b0;
			statusLatch_q <= 1'b0;
			doneLatch_q   <= 1'b0;
		end else if (!latchSel || switchSel) begin
			limitLatch_q  <= 1'b0;
			statusLatch_q <= 1'b0;
			doneLatch_q   <= 1'b0;
		end else begin
			if (srcLimit && !limitPrev_q) begin
				limitLatch_q <= 1'b1;
			end else if (resultRead) begin
				limitLatch_q <= 1'b0;
			end
			if (srcStatus && !statusPrev_q) begin
				statusLatch_q <= 1'b1;
			end else if (statusRead) begin
				statusLatch_q <= 1'b0;
			end
			if (srcDone && !donePrev_q) begin
				doneLatch_q <= 1'b1;
			end else if (resultRead) begin
				doneLatch_q <= 1'b0;
			end
		end
	end

	assign anyLatched = limitLatch_q || statusLatch_q || doneLatch_q;

	always_comb begin
		if (switchSel) begin
			alertActive = srcSwitch;
		end else if (latchSel) begin
			alertActive = anyLatched;
		end else begin
			alertActive = anySrc;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			alertPin_b <= 1'b1;
		end else begin
			alertPin_b <= !alertActive;
		end
	end

	// pin-pulse conversion triggering is blocked in switch mode
	assign alertTriggerEnable = !switchSel;

	AST_UNLATCHED_ASSERT: assert property (@(posedge mclk) disable iff (!rst_b)
		(!switchSel && !latchSel && anySrc) |=> !alertPin_b)
		else $error("alert not driven while source present");

	AST_UNLATCHED_RELEASE: assert property (@(posedge mclk) disable iff (!rst_b)
		(!switchSel && !latchSel && !anySrc) |=> alertPin_b)
		else $error("alert held after source went away");

	AST_LATCH_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
		(latchSel && !switchSel && limitLatch_q && !resultRead)
		##1 (latchSel && !switchSel) |-> limitLatch_q && !alertPin_b)
		else $error("latched limit alert dropped without a read");

	AST_LATCH_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
		(latchSel && statusLatch_q && statusRead && !(srcStatus && !statusPrev_q))
		|=> !statusLatch_q)
		else $error("status read did not clear latched alert");

	AST_LATCH_SET_WINS: assert property (@(posedge mclk) disable iff (!rst_b)
		(latchSel && !switchSel && srcDone && !donePrev_q && resultRead) |=> doneLatch_q)
		else $error("new completion lost to clearing read");

	AST_SWITCH_PIN: assert property (@(posedge mclk) disable iff (!rst_b)
		switchSel |=> alertPin_b == !$past(srcSwitch))
		else $error("switch mode pin does not follow axis limits");

	AST_SWITCH_NO_TRIGGER: assert property (@(posedge mclk) disable iff (!rst_b)
		switchSel |-> !alertTriggerEnable)
		else $error("pin trigger left on in switch mode");

	AST_STATUS_PIN: assert property (@(posedge mclk) disable iff (!rst_b)
		(!switchSel && !latchSel && alertCfg_q[SATS_BIT_STATUS] && systemStatusAny)
		|=> !alertPin_b)
		else $error("status flag did not drive alert");

	AST_DONE_BLOCKED: assert property (@(posedge mclk) disable iff (!rst_b)
		(!switchSel && !latchSel && !alertCfg_q[SATS_BIT_DONE] && !srcLimit && !srcStatus
		&& conversionSetDone) |=> alertPin_b)
		else $error("completion signalled while disabled");

	AST_AXIS_MASKED: assert property (@(posedge mclk) disable iff (!rst_b)
		(!switchSel && !latchSel && (pinEnable == 4'h0) && !srcStatus && !srcDone)
		|=> alertPin_b)
		else $error("masked limit crossing reached the pin");

endmodule

// *** sats_host_model.sv ***
// host side model: watches the alert pin the way a controller input would
module sats_host_model (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_b,
	// pin
	input  wire logic alertPin_b,
	// observations
	output logic      alertSeen,
	output logic [7:0] alertCount
);
	timeunit 1ns;
	timeprecision 1ps;

	logic pinLast_q;

	// a low level is an alert; an unknown level stays unknown so no compare can pass on it
	assign alertSeen = !alertPin_b;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pinLast_q  <= 1'b1;
			alertCount <= 8'h00;
		end else begin
			pinLast_q <= alertPin_b;
			if (pinLast_q && !alertPin_b) begin
				alertCount <= alertCount + 8'h01;
			end
		end
	end
endmodule

// *** sats_alert_tb.sv ***
// self-checking bench for the alert and limit-check block
`define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin nFail++; \
	$display("Error %s expected %h seen %h", nm, exp, got); end end
module sats_alert_tb
	import sats_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic               mclk, rst_b, regWrite, regRead, statusRead, resultRead;
	logic [3:0]         regAddr;
	logic [15:0]        regWriteData, regReadData, zLimits, tempLimits;
	logic               xValid, yValid, zValid, tempValid;
	logic signed [17:0] xValue, yValue, zValue, tempValue;
	logic [1:0]         xRange, yRange, zRange;
	logic [2:0]         limitCheckEnable;
	logic               frontEndStatusAny, systemStatusAny, conversionSetDone;
	logic               alertPin_b, alertTriggerEnable, alertSeen;
	logic [7:0]         alertCount;
	int                 nFail = 0;
	int                 nTests = 0;

	sats_alert u_sats_alert (.mclk(mclk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
		.statusRead(statusRead), .resultRead(resultRead), .xValid(xValid), .xValue(xValue),
		.yValid(yValid), .yValue(yValue), .zValid(zValid), .zValue(zValue),
		.tempValid(tempValid), .tempValue(tempValue), .xRange(xRange), .yRange(yRange),
		.zRange(zRange), .limitCheckEnable(limitCheckEnable), .zLimits(zLimits),
		.tempLimits(tempLimits), .frontEndStatusAny(frontEndStatusAny),
		.systemStatusAny(systemStatusAny), .conversionSetDone(conversionSetDone),
		.alertPin_b(alertPin_b), .alertTriggerEnable(alertTriggerEnable));

	sats_host_model u_sats_host_model (.mclk(mclk), .rst_b(rst_b), .alertPin_b(alertPin_b),
		.alertSeen(alertSeen), .alertCount(alertCount));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic tallyAndFinish;
		if (nFail == 0 && nTests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic tick(int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic wr(logic [3:0] a, logic [15:0] d);
		regAddr = a;
		regWriteData = d;
		regWrite = 1'b1;
		tick(1);
		regWrite = 1'b0;
		tick(1);
	endtask

	task automatic rdChk(logic [3:0] a, logic [15:0] e);
		regAddr = a;
		regRead = 1'b1;
		tick(1);
		regRead = 1'b0;
		`CHK("regReadData", e, regReadData)
		tick(1);
	endtask

	// one result pulse, then time for the hit register and the pin register to settle
	task automatic res(int ch, int v);
		case (ch)
			0: begin xValue = 18'(v); xValid = 1'b1; end
			1: begin yValue = 18'(v); yValid = 1'b1; end
			2: begin zValue = 18'(v); zValid = 1'b1; end
			default: begin tempValue = 18'(v); tempValid = 1'b1; end
		endcase
		tick(1);
		{xValid, yValid, zValid, tempValid} = 4'h0;
		tick(3);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(3);
	endtask

	task automatic tRegs;
		`CHK("alertPin_b", 1'b1, alertPin_b)
		rdChk(4'h3, 16'h0000);
		rdChk(4'h4, 16'h7D83);
		rdChk(4'h5, 16'h7D83);
		wr(4'h6, 16'hFFFF);
		rdChk(4'h6, 16'h0000);
		wr(4'h3, 16'hFFFF);
		rdChk(4'h3, 16'h393F);
		wr(4'h3, 16'h0000);
		wr(4'h4, 16'h10F0);
		wr(4'h5, 16'h10F0);
		rdChk(4'h4, 16'h10F0);
		rdChk(4'h5, 16'h10F0);
	endtask

	// upper code 16 and lower code -16 at range 1 put the limits at +-4096
	task automatic tCount;
		for (int c = 0; c < 4; c++) begin
			wr(4'h3, 16'h0001 | (16'(c) << 4));
			res(0, 0);
			for (int k = 0; k <= c; k++) begin
				res(0, (k % 2) ? -4097 : 4097);
				`CHK("alertSeen", (k == c), alertSeen)
			end
			res(0, 0);
			`CHK("alertSeen", 1'b0, alertSeen)
		end
	endtask

	task automatic tRange;
		int thr[4] = '{8192, 4096, 16384, 8192};
		wr(4'h3, 16'h0001);
		for (int r = 0; r < 4; r++) begin
			xRange = 2'(r);
			res(0, thr[r]);
			`CHK("alertSeen", 1'b0, alertSeen)
			res(0, thr[r] + 1);
			`CHK("alertSeen", 1'b1, alertSeen)
			res(0, -thr[r] - 1);
			`CHK("alertSeen", 1'b1, alertSeen)
			res(0, 0);
			`CHK("alertSeen", 1'b0, alertSeen)
		end
		xRange = 2'h1;
	endtask

	task automatic tEnables;
		for (int ch = 0; ch < 4; ch++) begin
			limitCheckEnable = 3'h0;
			wr(4'h3, 16'h0001 << ch);
			res(ch, 4097);
			`CHK("alertSeen", (ch == 3), alertSeen)
			res(ch, 0);
			limitCheckEnable = 3'h7;
			res(ch, 4097);
			`CHK("alertSeen", 1'b1, alertSeen)
			res(ch, 0);
			wr(4'h3, 16'h000F & ~(16'h0001 << ch));
			res(ch, 4097);
			`CHK("alertSeen", 1'b0, alertSeen)
			res(ch, 0);
		end
	endtask

	task automatic tStatus;
		wr(4'h3, 16'h0800);
		frontEndStatusAny = 1'b1;
		tick(2);
		`CHK("alertSeen", 1'b1, alertSeen)
		frontEndStatusAny = 1'b0;
		systemStatusAny = 1'b1;
		tick(2);
		`CHK("alertSeen", 1'b1, alertSeen)
		systemStatusAny = 1'b0;
		tick(2);
		`CHK("alertSeen", 1'b0, alertSeen)
		wr(4'h3, 16'h0100);
		systemStatusAny = 1'b1;
		conversionSetDone = 1'b1;
		tick(2);
		`CHK("alertSeen", 1'b1, alertSeen)
		wr(4'h3, 16'h0000);
		`CHK("alertSeen", 1'b0, alertSeen)
		systemStatusAny = 1'b0;
		conversionSetDone = 1'b0;
	endtask

	task automatic tLatch;
		logic [7:0] fallBase;
		wr(4'h3, 16'h2900);
		fallBase = alertCount;
		pulse(frontEndStatusAny);
		`CHK("alertSeen", 1'b1, alertSeen)
		pulse(resultRead);
		`CHK("alertSeen", 1'b1, alertSeen)
		pulse(statusRead);
		`CHK("alertSeen", 1'b0, alertSeen)
		pulse(conversionSetDone);
		pulse(statusRead);
		`CHK("alertSeen", 1'b1, alertSeen)
		pulse(resultRead);
		`CHK("alertSeen", 1'b0, alertSeen)
		// a latched limit alert outlives its source until the result read
		wr(4'h3, 16'h2901);
		res(0, 4097);
		`CHK("alertSeen", 1'b1, alertSeen)
		res(0, 0);
		`CHK("alertSeen", 1'b1, alertSeen)
		pulse(resultRead);
		`CHK("alertSeen", 1'b0, alertSeen)
		// a new completion in the cycle of a clearing read must still be caught
		conversionSetDone = 1'b1;
		resultRead = 1'b1;
		tick(1);
		{conversionSetDone, resultRead} = 2'h0;
		tick(3);
		`CHK("alertSeen", 1'b1, alertSeen)
		pulse(resultRead);
		`CHK("alertSeen", 1'b0, alertSeen)
		`CHK("alertCount", fallBase + 8'h04, alertCount)
	endtask

	task automatic tSwitch;
		wr(4'h3, 16'h0000);
		`CHK("alertTriggerEnable", 1'b1, alertTriggerEnable)
		limitCheckEnable = 3'h7;
		wr(4'h3, 16'h1809);
		`CHK("alertTriggerEnable", 1'b0, alertTriggerEnable)
		frontEndStatusAny = 1'b1;
		res(3, 4097);
		`CHK("alertSeen", 1'b0, alertSeen)
		frontEndStatusAny = 1'b0;
		res(3, 0);
		res(0, 4097);
		`CHK("alertSeen", 1'b1, alertSeen)
		res(0, 0);
		`CHK("alertSeen", 1'b0, alertSeen)
	endtask

	// no wait in the bench is open-ended, this only catches a stuck simulator
	initial begin
		#500us;
		nFail++;
		tallyAndFinish();
	end

	initial begin
		{rst_b, regWrite, regRead, statusRead, resultRead} = 5'h00;
		{xValid, yValid, zValid, tempValid} = 4'h0;
		{frontEndStatusAny, systemStatusAny, conversionSetDone} = 3'h0;
		regAddr = 4'h0;
		regWriteData = 16'h0000;
		{xValue, yValue, zValue, tempValue} = '0;
		{xRange, yRange, zRange} = 6'h15;
		limitCheckEnable = 3'h7;
		zLimits = 16'h10F0;
		tempLimits = 16'h10F0;
		repeat (10) @(posedge mclk);
		tick(1);
		rst_b = 1'b1;
		tick(1);
		tRegs();
		tCount();
		tRange();
		tEnables();
		tStatus();
		tLatch();
		tSwitch();
		tallyAndFinish();
	end
endmodule
